// ==== rtl/amc_pkg.sv ====
package amc_pkg;

  // ==========================================================
  // Serial bus addressing
  // ==========================================================
  localparam logic [6:0] AMC_DEV_ADDR = 7'h77;      // Write byte 8'hee, read byte 8'hef
  localparam logic [7:0] AMC_REG_RESULT_HI = 8'hfd;
  localparam logic [7:0] AMC_REG_RESULT_LO = 8'hfe;
  localparam logic [7:0] AMC_REG_CONFIG = 8'hff;
  // All ones leaves the wire released, so a stop after a run-on read still gets through
  localparam logic [7:0] AMC_UNMAPPED_READ = 8'hff;
  localparam logic AMC_SDA_DRIVE_LEVEL = 1'b0;       // Open drain: only ever pulls low

  // ==========================================================
  // Configuration register layout
  // ==========================================================
  localparam int AMC_CFG_OSR_HI = 7;
  localparam int AMC_CFG_OSR_LO = 6;
  localparam int AMC_CFG_GO = 5;
  localparam int AMC_CFG_PRESSURE = 4;
  localparam int AMC_CFG_RANGE = 3;
  localparam int AMC_CFG_DIV_DIS = 2;
  localparam int AMC_CFG_OFS_DIS = 1;
  localparam int AMC_CFG_OFS_SEL = 0;
  localparam logic [7:0] AMC_CFG_RESET = 8'h00;

  typedef struct packed {
    logic [1:0] oversampleSelect;  // 7:6
    logic conversionGo;            // 5
    logic pressureTempSelect;      // 4, 1 = pressure
    logic inputRangeSelect;        // 3, 1 = wide 405 mV
    logic clockDivideDisable;      // 2, 1 = internal clock equals master clock
    logic offsetDisable;           // 1, 1 = no offset
    logic offsetValueSelect;       // 0, 1 = +25 mV, 0 = +33 mV
  } amc_cfg_t;

  typedef struct packed {
    logic modulatorOn;
    logic pressureMode;
    logic wideRange;
    logic offsetOn;
    logic offsetWater;
  } amc_analog_t;

  localparam amc_analog_t AMC_ANALOG_RESET = '{default: 1'b0};

  // ==========================================================
  // Pins and conversion timing
  // ==========================================================
  localparam int AMC_PIN_COUNT = 4;
  localparam int AMC_PIN_SCL = 0;
  localparam int AMC_PIN_SDA = 1;
  localparam int AMC_PIN_MCLK = 2;
  localparam int AMC_PIN_XRST = 3;
  localparam logic [AMC_PIN_COUNT-1:0] AMC_PIN_RESET = 4'hf;
  localparam int AMC_TICK_W = 10;
  // Fixed decimator settling ticks on top of the ratio
  localparam logic [AMC_TICK_W-1:0] AMC_CONV_OVERHEAD_TICKS = 10'h00f;
  localparam int AMC_RESULT_W = 16;

  function automatic logic [AMC_TICK_W-1:0] oversampleRatio(input logic [1:0] sel);
    logic [AMC_TICK_W-1:0] r;
    r = 10'h040;
    unique case (sel)
      2'b11: r = 10'h200;
      2'b01: r = 10'h100;
      2'b10: r = 10'h080;
      2'b00: r = 10'h040;
    endcase
    return r;
  endfunction

endpackage

// ==== rtl/amc_pin_sync.sv ====
`timescale 1ns/1ps
module amc_pin_sync
  import amc_pkg::*;
(
  input wire logic clk_sys,                                  // system clock
  input wire logic rstn,                                     // sync reset, active low
  input wire logic [amc_pkg::AMC_PIN_COUNT-1:0] pinRaw,      // asynchronous pins
  output logic [amc_pkg::AMC_PIN_COUNT-1:0] pinLevel         // filtered levels
);
  import amc_pkg::*;

  logic [AMC_PIN_COUNT-1:0] s1_q, s2_q, s3_q, level_q, level_d;

  // ==========================================================
  // Three stages; level moves only when stages two and three agree
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < AMC_PIN_COUNT; i++) begin : g_pin
      always_comb begin
        level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q <= AMC_PIN_RESET;
      s2_q <= AMC_PIN_RESET;
      s3_q <= AMC_PIN_RESET;
      level_q <= AMC_PIN_RESET;
    end else begin
      s1_q <= pinRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign pinLevel = level_q;

endmodule

// ==== rtl/amc_conv_seq.sv ====
`timescale 1ns/1ps
module amc_conv_seq
  import amc_pkg::*;
(
  input wire logic clk_sys,            // system clock
  input wire logic rstInt,             // combined reset, active high
  input wire logic startPulse,         // begin a conversion
  input wire logic abortPulse,         // go bit written to 0
  input wire logic mclkRise,           // one pulse per master clock rising edge
  input wire logic [1:0] osrSel,       // oversample_select
  input wire logic divDisable,         // clock_divide_disable
  output logic busy,                   // conversion running
  output logic done                    // one-cycle pulse at completion
);
  import amc_pkg::*;

  typedef enum logic {AMC_IDLE, AMC_RUN} amc_conv_state_t;

  amc_conv_state_t state_q, state_d;
  logic [AMC_TICK_W-1:0] cnt_q, cnt_d, target_q, target_d;
  logic divPhase_q, divPhase_d;
  logic tick;
  logic done_d, done_q;

  // ==========================================================
  // Internal clock tick: every master edge, or every second one
  // ==========================================================
  always_comb begin
    tick = mclkRise & (divDisable | divPhase_q);
    state_d = state_q;
    cnt_d = cnt_q;
    target_d = target_q;
    divPhase_d = divPhase_q;
    done_d = 1'b0;
    unique case (state_q)
      AMC_IDLE: begin
      end
      AMC_RUN: begin
        if (mclkRise) begin
          divPhase_d = ~divPhase_q;
        end
        if (tick) begin
          if (cnt_q == target_q - 10'h001) begin
            state_d = AMC_IDLE;
            done_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 10'h001;
          end
        end
      end
    endcase
    if (abortPulse) begin
      state_d = AMC_IDLE;
    end
    if (startPulse) begin
      state_d = AMC_RUN;
      cnt_d = '0;
      divPhase_d = 1'b0;
      // Length grows with the selected ratio
      target_d = oversampleRatio(osrSel) + AMC_CONV_OVERHEAD_TICKS;
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rstInt) begin
      state_q <= AMC_IDLE;
      cnt_q <= '0;
      target_q <= '0;
      divPhase_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      target_q <= target_d;
      divPhase_q <= divPhase_d;
      done_q <= done_d;
    end
  end

  assign busy = (state_q == AMC_RUN);
  assign done = done_q;

endmodule

// ==== rtl/amc_config_control.sv ====
`timescale 1ns/1ps
// Operation
// - Bits 7:6 pick ratio 512/256/128/64; the code gives 512 for 11, 256 for 01, 128 for 10, 64 for 00
// - Higher ratio gives longer conversion
// - Go bit 0 idles; 1 starts conversion
// - End-of-conversion rises when conversion finishes
// - Bit 4: pressure 1, temperature 0
// - Bit 3: wide range 1, narrow 0
// - Bit 2 high: no master clock division
// - Divided mode takes twice as long
// - Bit 1 high disables input offset
// - Bit 0 picks offset, ignored when disabled
// - Configuration only via the serial bus
// - Decode ff config, fd high, fe low
// - Answer bus address 1110111 only
// - Continued read increments register pointer
// - External reset pin initializes all state; the pin synchroniser stages are reset by rstn only
module amc_config_control
  import amc_pkg::*;
(
  input wire logic clk_sys,                                      // system clock, 200 MHz
  input wire logic rstn,                                         // sync reset, active low
  input wire logic externalResetN,                               // external_reset_n pin
  input wire logic sclIn,                                        // serial clock pin
  input wire logic sdaIn,                                        // serial data pin level
  output logic sdaOut,                                           // serial data drive value
  output logic sdaOeN,                                           // low while pulling data low
  input wire logic mclkIn,                                       // master clock pin
  input wire logic [amc_pkg::AMC_RESULT_W-1:0] adcResult,        // decimator output
  output logic endOfConversion,                                  // result ready
  output amc_pkg::amc_analog_t analogCtl,                        // analog front-end controls
  output amc_pkg::amc_cfg_t cfgOut                               // configuration register
);
  import amc_pkg::*;

  typedef enum logic [3:0] {
    AMC_BUS_IDLE, AMC_DEVADDR, AMC_ADDRACK, AMC_REGADDR, AMC_REGACK,
    AMC_WDATA, AMC_WACK, AMC_RDATA, AMC_RACK
  } amc_bus_state_t;

  // ==========================================================
  // Pin sampling and reset
  // ==========================================================
  logic [AMC_PIN_COUNT-1:0] pinRaw, pinLevel;
  logic sclL, sdaL, mclkL, xrstL;
  logic sclPrev_q, sdaPrev_q, mclkPrev_q;
  logic rstInt;

  assign pinRaw = {externalResetN, mclkIn, sdaIn, sclIn};

  amc_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinRaw(pinRaw),
    .pinLevel(pinLevel)
  );

  assign sclL = pinLevel[AMC_PIN_SCL];
  assign sdaL = pinLevel[AMC_PIN_SDA];
  assign mclkL = pinLevel[AMC_PIN_MCLK];
  assign xrstL = pinLevel[AMC_PIN_XRST];
  // External pin clears every register and counter as rstn does, except the pin synchroniser stages, which only rstn resets
  assign rstInt = ~rstn | ~xrstL;

  always_ff @(posedge clk_sys) begin
    if (rstInt) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      // Same level as the synchroniser's reset, so no false rise after release
      mclkPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclL;
      sdaPrev_q <= sdaL;
      mclkPrev_q <= mclkL;
    end
  end

  logic sclRise, sclFall, startCond, stopCond, mclkRise;
  assign sclRise = sclL & ~sclPrev_q;
  assign sclFall = ~sclL & sclPrev_q;
  assign startCond = sclL & sclPrev_q & sdaPrev_q & ~sdaL;
  assign stopCond = sclL & sclPrev_q & ~sdaPrev_q & sdaL;
  // Master clock is sampled; no edge is trusted outside of a conversion
  assign mclkRise = mclkL & ~mclkPrev_q;

  // ==========================================================
  // Register state
  // ==========================================================
  amc_cfg_t cfg_q, cfg_d;
  logic [AMC_RESULT_W-1:0] result_q, result_d;
  logic eoc_q, eoc_d;
  amc_analog_t analog_q, analog_d;
  logic convBusy, convDone;

  function automatic logic [7:0] regRead(input logic [7:0] ptr, input amc_cfg_t cfg,
                                         input logic [AMC_RESULT_W-1:0] res);
    logic [7:0] v;
    v = AMC_UNMAPPED_READ;
    if (ptr == AMC_REG_RESULT_HI) begin
      v = res[15:8];
    end else if (ptr == AMC_REG_RESULT_LO) begin
      v = res[7:0];
    end else if (ptr == AMC_REG_CONFIG) begin
      v = cfg;
    end
    return v;
  endfunction

  // ==========================================================
  // Serial bus slave
  // ==========================================================
  amc_bus_state_t bus_q, bus_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ptr_q, ptr_d;
  logic readMode_q, readMode_d;
  logic drvLow_q, drvLow_d;
  logic cfgWrEn;
  logic [7:0] cfgWrData;

  always_comb begin
    bus_d = bus_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    readMode_d = readMode_q;
    drvLow_d = drvLow_q;
    cfgWrEn = 1'b0;
    cfgWrData = shift_q;
    if (startCond) begin
      // Repeated start keeps the pointer for the read that follows
      bus_d = AMC_DEVADDR;
      bitCnt_d = '0;
      drvLow_d = 1'b0;
    end else if (stopCond) begin
      bus_d = AMC_BUS_IDLE;
      drvLow_d = 1'b0;
    end else if (sclRise) begin
      if (bus_q == AMC_DEVADDR || bus_q == AMC_REGADDR || bus_q == AMC_WDATA) begin
        shift_d = {shift_q[6:0], sdaL};
        bitCnt_d = bitCnt_q + 4'h1;
      end
    end else if (sclFall) begin
      unique case (bus_q)
        AMC_BUS_IDLE: begin
        end
        AMC_DEVADDR: begin
          if (bitCnt_q == 4'h8) begin
            if (shift_q[7:1] == AMC_DEV_ADDR) begin
              bus_d = AMC_ADDRACK;
              readMode_d = shift_q[0];
              drvLow_d = 1'b1;
            end else begin
              bus_d = AMC_BUS_IDLE;
            end
          end
        end
        AMC_ADDRACK: begin
          bitCnt_d = '0;
          if (readMode_q) begin
            bus_d = AMC_RDATA;
            tx_d = regRead(ptr_q, cfg_q, result_q);
            drvLow_d = ~tx_d[7];
          end else begin
            bus_d = AMC_REGADDR;
            drvLow_d = 1'b0;
          end
        end
        AMC_REGADDR: begin
          if (bitCnt_q == 4'h8) begin
            ptr_d = shift_q;
            bus_d = AMC_REGACK;
            drvLow_d = 1'b1;
          end
        end
        AMC_REGACK, AMC_WACK: begin
          bus_d = AMC_WDATA;
          bitCnt_d = '0;
          drvLow_d = 1'b0;
        end
        AMC_WDATA: begin
          if (bitCnt_q == 4'h8) begin
            // Only the configuration register is writable from the bus
            cfgWrEn = (ptr_q == AMC_REG_CONFIG);
            bus_d = AMC_WACK;
            drvLow_d = 1'b1;
          end
        end
        AMC_RDATA: begin
          if (bitCnt_q == 4'h7) begin
            bus_d = AMC_RACK;
            drvLow_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            bitCnt_d = bitCnt_q + 4'h1;
            drvLow_d = ~tx_q[6];
          end
        end
        AMC_RACK: begin
          // Master acknowledge is not needed to continue; stop ends the read
          bus_d = AMC_RDATA;
          bitCnt_d = '0;
          tx_d = regRead(ptr_q, cfg_q, result_q);
          drvLow_d = ~tx_d[7];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rstInt) begin
      bus_q <= AMC_BUS_IDLE;
      bitCnt_q <= '0;
      shift_q <= '0;
      tx_q <= '0;
      ptr_q <= '0;
      readMode_q <= 1'b0;
      drvLow_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      readMode_q <= readMode_d;
      drvLow_q <= drvLow_d;
    end
  end

  assign sdaOut = AMC_SDA_DRIVE_LEVEL;
  assign sdaOeN = ~drvLow_q;

  // ==========================================================
  // Conversion sequencing
  // ==========================================================
  logic startPulse, abortPulse;
  assign startPulse = cfgWrEn & cfgWrData[AMC_CFG_GO];
  assign abortPulse = cfgWrEn & ~cfgWrData[AMC_CFG_GO];

  amc_conv_seq u_conv (
    .clk_sys(clk_sys),
    .rstInt(rstInt),
    .startPulse(startPulse),
    .abortPulse(abortPulse),
    .mclkRise(mclkRise),
    .osrSel(cfgWrData[AMC_CFG_OSR_HI:AMC_CFG_OSR_LO]),
    .divDisable(cfg_q.clockDivideDisable),
    .busy(convBusy),
    .done(convDone)
  );

  always_comb begin
    cfg_d = cfg_q;
    result_d = result_q;
    eoc_d = eoc_q;
    if (convDone) begin
      result_d = adcResult;
      eoc_d = 1'b1;
      cfg_d.conversionGo = 1'b0;
    end
    // A write landing with completion wins, so a new go is never lost
    if (cfgWrEn) begin
      cfg_d = cfgWrData;
    end
    if (startPulse) begin
      eoc_d = 1'b0;
    end
  end

  // ==========================================================
  // Analog front-end controls
  // ==========================================================
  always_comb begin
    analog_d.modulatorOn = convBusy;
    analog_d.pressureMode = cfg_q.pressureTempSelect;
    analog_d.wideRange = cfg_q.inputRangeSelect;
    analog_d.offsetOn = ~cfg_q.offsetDisable;
    // Offset select has no effect with offset disabled
    analog_d.offsetWater = ~cfg_q.offsetDisable & cfg_q.offsetValueSelect;
  end

  always_ff @(posedge clk_sys) begin
    if (rstInt) begin
      cfg_q <= AMC_CFG_RESET;
      result_q <= '0;
      eoc_q <= 1'b0;
      analog_q <= AMC_ANALOG_RESET;
    end else begin
      cfg_q <= cfg_d;
      result_q <= result_d;
      eoc_q <= eoc_d;
      analog_q <= analog_d;
    end
  end

  assign endOfConversion = eoc_q;
  assign analogCtl = analog_q;
  assign cfgOut = cfg_q;

endmodule

// ==== tb/amc_config_control_chk.sv ====
`timescale 1ns/1ps
module amc_config_control_chk
  import amc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset
  input wire logic externalResetN, // pin reset
  input wire logic sclIn, // bus clock
  input wire logic sdaOeN, // data drive
  input wire logic endOfConversion, // ready
  input wire amc_pkg::amc_analog_t analogCtl, // front end
  input wire amc_pkg::amc_cfg_t cfgOut // config
);
  // ==========================================
  // History of reset and bus clock
  // ==========================================
  logic [19:0] histQ, histD;
  always_comb begin
    histD = {histQ[18:12], rstn & externalResetN, histQ[10:0], sclIn};
    if (!rstn) begin
      histD[19:12] = 8'h00;
    end
  end
  always_ff @(posedge clk_sys) begin
    histQ <= histD;
  end
  // Pin reset is synchronised late, so keep checks off for a while
  // Unknown history before the first reset edge counts as not ready
  wire ok = (histQ[19:12] === 8'hff);
  wire sclFell = |(histQ[11:1] & ~histQ[10:0]);

  // ==========================================
  // Properties
  // ==========================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!ok);
  sequence runStart;
    $rose(cfgOut.conversionGo);
  endsequence
  sequence eocLowHeld;
    !endOfConversion [*8];
  endsequence

  a_reset_idle: assert property (disable iff (1'b0)
    !rstn |=> sdaOeN && !endOfConversion && cfgOut == AMC_CFG_RESET && analogCtl == AMC_ANALOG_RESET)
    else $error("reset state wrong");
  a_eoc_low_run: assert property (runStart |-> ##[0:1] eocLowHeld)
    else $error("ready high while converting");
  a_eoc_fall_start: assert property ($fell(endOfConversion) |-> ##[0:1] cfgOut.conversionGo)
    else $error("ready fell without start");
  a_go_self_clear: assert property ($rose(endOfConversion) |-> ##[0:2] !cfgOut.conversionGo)
    else $error("go bit kept after done");
  a_eoc_after_run: assert property ($rose(endOfConversion) |-> $past(analogCtl.modulatorOn))
    else $error("ready without conversion");
  a_modulator_on: assert property (cfgOut.conversionGo ##1 cfgOut.conversionGo |-> analogCtl.modulatorOn)
    else $error("modulator off while running");
  a_mode_map: assert property (analogCtl.pressureMode == $past(cfgOut.pressureTempSelect)
    && analogCtl.wideRange == $past(cfgOut.inputRangeSelect))
    else $error("mode or range control wrong");
  a_offset_map: assert property (analogCtl.offsetOn == !$past(cfgOut.offsetDisable)
    && (!analogCtl.offsetOn || analogCtl.offsetWater == $past(cfgOut.offsetValueSelect)))
    else $error("offset control wrong");
  a_cfg_by_bus: assert property ($changed({cfgOut[7:6], cfgOut[4:0]}) |-> sclFell)
    else $error("config changed off the bus");
endmodule

bind amc_config_control amc_config_control_chk chk (.clk_sys(clk_sys), .rstn(rstn),
  .externalResetN(externalResetN), .sclIn(sclIn), .sdaOeN(sdaOeN),
  .endOfConversion(endOfConversion), .analogCtl(analogCtl), .cfgOut(cfgOut));

// ==== tb/amc_host.sv ====
`timescale 1ns/1ps
module amc_host (
  input wire logic clk_sys, // system clock
  input wire logic sdaWire, // data wire level
  output logic sclPin, // bus clock
  output logic sdaPull, // high pulls data low
  output logic mclkPin // master clock
);
  logic [7:0] lastByte;
  event byteEv;
  initial begin
    sclPin = 1'b1;
    sdaPull = 1'b0;
  end
  // Free running, even duty, 8 system cycles a period
  initial begin
    mclkPin = 1'b0;
    forever begin
      repeat (4) @(posedge clk_sys);
      #1 mclkPin = ~mclkPin;
    end
  end

  // ==========================================
  // Bus cycles
  // ==========================================
  task automatic hw(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Data moves only mid low phase, well clear of both clock edges
  task automatic clkBit(input logic pull, output logic seen);
    hw(10);
    sdaPull = pull;
    hw(10);
    sclPin = 1'b1;
    hw(20);
    seen = sdaWire;
    sclPin = 1'b0;
  endtask
  task automatic start();
    hw(10);
    sdaPull = 1'b0;
    hw(10);
    sclPin = 1'b1;
    hw(20);
    sdaPull = 1'b1;
    hw(20);
    sclPin = 1'b0;
  endtask
  task automatic stop();
    hw(10);
    sdaPull = 1'b1;
    hw(10);
    sclPin = 1'b1;
    hw(20);
    sdaPull = 1'b0;
    hw(20);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clkBit(~b[i], s);
    end
    clkBit(1'b0, ack);
  endtask
  task automatic recvByte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clkBit(1'b0, b[i]);
    end
    clkBit(1'b0, s);
    lastByte = b;
    ->byteEv;
  endtask
endmodule

// ==== tb/tb_adc_measurement_config_control.sv ====
`timescale 1ns/1ps
module tb_adc_measurement_config_control;
  import amc_pkg::*;
  logic clk_sys, rstn, externalResetN, sdaWire, sdaOut, sdaOeN, endOfConversion;
  logic sclPin, sdaPull, mclkPin;
  logic [15:0] adcResult;
  amc_analog_t analogCtl;
  amc_cfg_t cfgOut;
  int nMismatch, nCompared, cycles, rises;
  int osrTab[4] = '{64, 256, 128, 512};
  int qConv[$];
  logic [7:0] qByte[$];
  // Pull-up on the data wire
  assign sdaWire = !(sdaPull || (!sdaOeN && !sdaOut));

  amc_config_control uut (.clk_sys(clk_sys), .rstn(rstn), .externalResetN(externalResetN),
    .sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .mclkIn(mclkPin),
    .adcResult(adcResult), .endOfConversion(endOfConversion), .analogCtl(analogCtl), .cfgOut(cfgOut));
  amc_host host (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclPin(sclPin), .sdaPull(sdaPull),
    .mclkPin(mclkPin));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Compare and report
  // ==========================================
  task automatic cmpVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pin synchronisers may shift the count by up to two master clock edges
  task automatic cmpNear(input string what, input int exp, input int got);
    nCompared++;
    if (got < exp - 2 || got > exp + 2) begin
      nMismatch++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic reportAndStop();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      nMismatch++;
      $display("Error timeout");
      reportAndStop();
    end
  end

  // ==========================================
  // Monitors
  // ==========================================
  always @(posedge cfgOut.conversionGo) rises = 0;
  always @(posedge mclkPin) if (cfgOut.conversionGo && !endOfConversion) rises++;
  always @(posedge endOfConversion) begin
    int e;
    e = qConv.pop_front();
    cmpNear("conversion length", e, rises);
  end
  always @(host.byteEv) begin
    cmpVal("read byte", {8'h00, qByte.pop_front()}, {8'h00, host.lastByte});
  end

  // ==========================================
  // Bus transactions
  // ==========================================
  task automatic regWrite(input logic [7:0] ptr, input logic [7:0] data);
    logic a;
    host.start();
    host.sendByte(8'hee, a);
    cmpVal("write address ack", 16'h0000, {15'h0000, a});
    host.sendByte(ptr, a);
    host.sendByte(data, a);
    host.stop();
  endtask
  task automatic regRead3(input logic [7:0] ptr);
    logic a;
    logic [7:0] b;
    host.start();
    host.sendByte(8'hee, a);
    host.sendByte(ptr, a);
    host.start();
    host.sendByte(8'hef, a);
    repeat (3) host.recvByte(b);
    host.stop();
  endtask

  initial begin
    logic [7:0] cfg;
    logic a;
    rstn = 1'b0;
    externalResetN = 1'b1;
    adcResult = 16'h0000;
    void'($urandom(56198));
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    cmpVal("config reset", 16'h0000, {8'h00, cfgOut});
    cmpVal("ready reset", 16'h0000, {15'h0000, endOfConversion});
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      cfg = 8'($urandom());
      cfg[7:5] = {k[1:0], 1'b1};
      cfg[2] = k[2];
      adcResult = 16'($urandom());
      qConv.push_back((osrTab[k[1:0]] + int'(AMC_CONV_OVERHEAD_TICKS)) * (k[2] ? 1 : 2));
      regWrite(AMC_REG_CONFIG, cfg);
      for (int t = 0; t < 12000 && endOfConversion !== 1'b1; t++) @(posedge clk_sys);
      #1;
      cmpVal("config after run", {8'h00, cfg & 8'hdf}, {8'h00, cfgOut});
      cmpVal("pressure control", {15'h0000, cfg[4]}, {15'h0000, analogCtl.pressureMode});
      cmpVal("range control", {15'h0000, cfg[3]}, {15'h0000, analogCtl.wideRange});
      repeat (32) @(posedge clk_sys);
      #1;
      qByte.push_back(adcResult[15:8]);
      qByte.push_back(adcResult[7:0]);
      qByte.push_back(cfg & 8'hdf);
      regRead3(AMC_REG_RESULT_HI);
      $display("test conversion %0d done", k);
    end
    host.start();
    host.sendByte(8'hec, a);
    host.stop();
    cmpVal("foreign address ack", 16'h0001, {15'h0000, a});
    regWrite(AMC_REG_RESULT_LO, 8'h5a);
    cmpVal("config kept", {8'h00, cfg & 8'hdf}, {8'h00, cfgOut});
    $display("test addressing done");
    regWrite(AMC_REG_CONFIG, 8'he4);
    regWrite(AMC_REG_CONFIG, 8'hc4);
    repeat (5000) @(posedge clk_sys);
    #1;
    cmpVal("ready after abort", 16'h0000, {15'h0000, endOfConversion});
    $display("test abort done");
    externalResetN = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 externalResetN = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    cmpVal("config after pin reset", 16'h0000, {8'h00, cfgOut});
    $display("test pin reset done");
    reportAndStop();
  end
endmodule
